// *** hw/tpp_pkg.sv ***
package tpp_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int TPP_DW = 16;
  localparam int TPP_AW = 5;
  localparam int TPP_DTW = 8;
  localparam int TPP_PH = 3;

  // ****************************************
  // register word offsets
  // ****************************************
  localparam logic [TPP_AW-1:0] TPP_REG_CTRL = 5'h00;
  localparam logic [TPP_AW-1:0] TPP_REG_PERIOD = 5'h01;
  localparam logic [TPP_AW-1:0] TPP_REG_DEAD = 5'h02;
  localparam logic [TPP_AW-1:0] TPP_REG_STATUS = 5'h03;
  localparam logic [TPP_AW-1:0] TPP_REG_PRI = 5'h04;
  localparam logic [TPP_AW-1:0] TPP_REG_ALT = 5'h07;
  localparam logic [TPP_AW-1:0] TPP_REG_SHADOW = 5'h0A;
  localparam logic [TPP_AW-1:0] TPP_SHADOW_STRIDE = 5'h02;

  // ****************************************
  // status field positions
  // ****************************************
  localparam int TPP_ST_RUN = 0;
  localparam int TPP_ST_LOST = 1;
  localparam int TPP_ST_RISK = 4;

  // ****************************************
  // modulation modes and reset values
  // ****************************************
  localparam logic [1:0] TPP_MODE_TRI0 = 2'h0;
  localparam logic [1:0] TPP_MODE_TRI1 = 2'h1;
  localparam logic [1:0] TPP_MODE_SAW = 2'h2;
  localparam logic [TPP_DW-1:0] TPP_PERIOD_RST = 16'hffff;
  localparam logic [TPP_DW-1:0] TPP_CMP_RST = 16'h0000;
  localparam logic [TPP_DTW-1:0] TPP_DEAD_RST = 8'h00;
  localparam logic [TPP_DW-1:0] TPP_ZERO = 16'h0000;
  localparam logic [TPP_DW-1:0] TPP_ONE = 16'h0001;
  localparam logic [TPP_DTW-1:0] TPP_DEAD_ZERO = 8'h00;
  localparam logic [TPP_DTW-1:0] TPP_DEAD_ONE = 8'h01;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic deadEn;
    logic deadDiv2;
    logic [1:0] mode;
    logic run;
  } tpp_cfg_s;

  localparam int TPP_CFG_W = $bits(tpp_cfg_s);
  localparam tpp_cfg_s TPP_CFG_RST = '0;

  typedef struct packed {
    logic hi;
    logic lo;
  } tpp_drive_s;

  typedef enum logic [2:0] {
    TPP_RUN_IDLE = 3'b001,
    TPP_RUN_WAIT = 3'b010,
    TPP_RUN_PHASE = 3'b100
  } tpp_run_e;

endpackage : tpp_pkg

// *** hw/tpp_phase.sv ***
`timescale 1ns/10ps
module tpp_phase
  import tpp_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic start,
  input wire logic running,
  input wire logic [TPP_DW-1:0] cmp,
  input wire logic cmpCount,
  input wire logic cmpEdge,
  input wire logic loadLevel,
  input wire logic startLevel,
  input wire logic expLevel,
  input wire logic [TPP_DTW-1:0] deadValue,
  input wire logic deadEn,
  input wire logic deadTick,
  output tpp_drive_s drive,
  output logic lost
);

  logic [TPP_DW-1:0] tmr, next_tmr;
  logic counting, next_counting;
  logic armed, next_armed;
  logic ideal, next_ideal;
  logic [TPP_DTW-1:0] deadCnt, next_deadCnt;
  tpp_drive_s next_drive;
  logic next_lost;
  logic expire;

  // ****************************************
  // phase timer and dead time
  // ****************************************
  always_comb
  begin
    next_tmr = tmr;
    next_counting = counting;
    next_armed = armed;
    next_ideal = ideal;
    next_deadCnt = deadCnt;
    next_lost = 1'b0;
    expire = armed && counting && ((tmr + TPP_ONE) == cmp);
    if (start)
    begin
      next_tmr = TPP_ZERO;
      next_counting = cmpCount;
      next_armed = cmpEdge;
      if (loadLevel)
      begin
        next_ideal = startLevel;
      end
    end
    else if (counting)
    begin
      next_tmr = tmr + TPP_ONE;
      if (expire)
      begin
        next_ideal = expLevel;
        next_armed = 1'b0;
      end
    end
    if (!running)
    begin
      next_counting = 1'b0;
      next_armed = 1'b0;
      next_ideal = 1'b0;
    end
    if (deadCnt != TPP_DEAD_ZERO && deadTick)
    begin
      next_deadCnt = deadCnt - TPP_DEAD_ONE;
    end
    if (next_ideal != ideal && deadEn)
    begin
      if (deadCnt != TPP_DEAD_ZERO)
      begin
        next_lost = 1'b1;
      end
      else
      begin
        next_deadCnt = deadValue;
      end
    end
    next_drive.hi = next_ideal && (next_deadCnt == TPP_DEAD_ZERO);
    next_drive.lo = running && !next_ideal && (next_deadCnt == TPP_DEAD_ZERO);
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      tmr <= TPP_ZERO;
      counting <= 1'b0;
      armed <= 1'b0;
      ideal <= 1'b0;
      deadCnt <= TPP_DEAD_ZERO;
      drive <= '0;
      lost <= 1'b0;
    end
    else if (ce)
    begin
      tmr <= next_tmr;
      counting <= next_counting;
      armed <= next_armed;
      ideal <= next_ideal;
      deadCnt <= next_deadCnt;
      drive <= next_drive;
      lost <= next_lost;
    end
  end

endmodule : tpp_phase

// *** hw/tpp_pwm.sv ***
// How it works
// - mirror write loads identical compare value
// - mirrors of all phases contiguous for burst
// - compare zero: no count, level held
// - compare above period: no edge, level held
// - activation during dead time is lost
// - triangular mode 0 restart-loss condition flagged unless deadDiv2
// - triangular mode 1 restart-loss condition flagged unless deadDiv2
// - sawtooth restart-loss condition flagged unless deadDiv2
// - phases start at first carrier underflow
`timescale 1ns/10ps
module tpp_pwm
  import tpp_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [TPP_AW-1:0] addr,
  input wire logic [TPP_DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [TPP_DW-1:0] rdata,
  output logic [TPP_PH-1:0] phaseHi,
  output logic [TPP_PH-1:0] phaseLo,
  output logic carrierUnderflow
);

  tpp_cfg_s cfg, next_cfg;
  logic [TPP_DW-1:0] period, next_period;
  logic [TPP_DTW-1:0] deadValue, next_deadValue;
  logic [TPP_PH-1:0] lostFlag, next_lostFlag;
  logic [TPP_DW-1:0] next_rdata;
  logic [TPP_DW-1:0] carrierCnt, next_carrierCnt;
  logic half, next_half;
  logic deadPhase, next_deadPhase;
  logic next_carrierUnderflow;
  tpp_run_e runState, next_runState;

  logic [TPP_DW-1:0] cmpPri [TPP_PH];
  logic [TPP_DW-1:0] cmpAlt [TPP_PH];
  logic [TPP_PH-1:0] lostPulse;
  logic [TPP_PH-1:0] risk;
  tpp_drive_s drive [TPP_PH];
  logic [TPP_PH-1:0] driveHi;
  logic [TPP_PH-1:0] driveLo;

  logic underflow;
  logic phaseStart;
  logic running;
  logic phasesRun;
  logic deadTick;
  logic isTri;
  logic loadLevel;
  logic startLevel;
  logic expLevel;
  logic [TPP_DW-1:0] cmpMin;
  logic [TPP_DW-1:0] cmpLimit;
  logic [TPP_DW-1:0] statusWord;

  // ****************************************
  // carrier period timer
  // ****************************************
  assign running = cfg.run && (runState != TPP_RUN_IDLE);
  assign phasesRun = (runState == TPP_RUN_PHASE);
  assign underflow = running && (carrierCnt == TPP_ZERO);
  assign phaseStart = underflow;
  assign isTri = (cfg.mode != TPP_MODE_SAW);
  assign loadLevel = !isTri;
  assign startLevel = 1'b1;
  assign expLevel = isTri ? !half : 1'b0;
  assign deadTick = cfg.deadDiv2 ? deadPhase : 1'b1;
  assign cmpMin = cfg.deadDiv2 ? TPP_ONE : TPP_ZERO;
  assign cmpLimit = cfg.deadDiv2 ? (period - TPP_ONE) : period;

  always_comb
  begin
    next_runState = runState;
    next_carrierCnt = carrierCnt;
    next_half = half;
    next_deadPhase = !deadPhase;
    next_carrierUnderflow = underflow;
    case (runState)
      TPP_RUN_IDLE:
      begin
        next_half = 1'b0;
        if (cfg.run)
        begin
          next_runState = TPP_RUN_WAIT;
          next_carrierCnt = period;
        end
      end
      TPP_RUN_WAIT:
      begin
        if (underflow)
        begin
          next_runState = TPP_RUN_PHASE;
          next_carrierCnt = period;
          next_half = 1'b0;
        end
        else
        begin
          next_carrierCnt = carrierCnt - TPP_ONE;
        end
      end
      TPP_RUN_PHASE:
      begin
        if (underflow)
        begin
          next_carrierCnt = period;
          next_half = isTri ? !half : 1'b0;
        end
        else
        begin
          next_carrierCnt = carrierCnt - TPP_ONE;
        end
      end
      default:
      begin
        next_runState = TPP_RUN_IDLE;
      end
    endcase
    if (!cfg.run)
    begin
      next_runState = TPP_RUN_IDLE;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      runState <= TPP_RUN_IDLE;
      carrierCnt <= TPP_ZERO;
      half <= 1'b0;
      deadPhase <= 1'b0;
      carrierUnderflow <= 1'b0;
    end
    else if (ce)
    begin
      runState <= next_runState;
      carrierCnt <= next_carrierCnt;
      half <= next_half;
      deadPhase <= next_deadPhase;
      carrierUnderflow <= next_carrierUnderflow;
    end
  end

  // ****************************************
  // common registers and read port
  // ****************************************
  always_comb
  begin
    statusWord = TPP_ZERO;
    statusWord[TPP_ST_RUN] = phasesRun;
    statusWord[TPP_ST_LOST +: TPP_PH] = lostFlag;
    statusWord[TPP_ST_RISK +: TPP_PH] = risk;
  end

  always_comb
  begin
    next_cfg = cfg;
    next_period = period;
    next_deadValue = deadValue;
    next_lostFlag = lostFlag;
    next_rdata = TPP_ZERO;
    if (wr)
    begin
      case (addr)
        TPP_REG_CTRL: next_cfg = wdata[TPP_CFG_W-1:0];
        TPP_REG_PERIOD: next_period = wdata;
        TPP_REG_DEAD: next_deadValue = wdata[TPP_DTW-1:0];
        TPP_REG_STATUS: next_lostFlag = lostFlag & ~wdata[TPP_ST_LOST +: TPP_PH];
        default: next_lostFlag = lostFlag;
      endcase
    end
    // hardware set wins over a same-cycle clear
    next_lostFlag = next_lostFlag | lostPulse;
    if (rd)
    begin
      next_rdata = TPP_ZERO;
      case (addr)
        TPP_REG_CTRL: next_rdata[TPP_CFG_W-1:0] = cfg;
        TPP_REG_PERIOD: next_rdata = period;
        TPP_REG_DEAD: next_rdata[TPP_DTW-1:0] = deadValue;
        TPP_REG_STATUS: next_rdata = statusWord;
        default: next_rdata = TPP_ZERO;
      endcase
      for (int i = 0; i < TPP_PH; i++)
      begin
        if (addr == TPP_REG_PRI + i[TPP_AW-1:0] || addr == TPP_REG_SHADOW + TPP_SHADOW_STRIDE * i[TPP_AW-1:0])
        begin
          next_rdata = cmpPri[i];
        end
        if (addr == TPP_REG_ALT + i[TPP_AW-1:0]
            || addr == TPP_REG_SHADOW + TPP_SHADOW_STRIDE * i[TPP_AW-1:0] + 5'h01)
        begin
          next_rdata = cmpAlt[i];
        end
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cfg <= TPP_CFG_RST;
      period <= TPP_PERIOD_RST;
      deadValue <= TPP_DEAD_RST;
      lostFlag <= '0;
      rdata <= TPP_ZERO;
    end
    else if (ce)
    begin
      cfg <= next_cfg;
      period <= next_period;
      deadValue <= next_deadValue;
      lostFlag <= next_lostFlag;
      rdata <= next_rdata;
    end
  end

  // ****************************************
  // per-phase compare, predictor, timer
  // ****************************************
  for (genvar g = 0; g < TPP_PH; g++)
  begin : gPhase
    localparam logic [TPP_AW-1:0] PRI_ADDR = TPP_REG_PRI + TPP_AW'(g);
    localparam logic [TPP_AW-1:0] ALT_ADDR = TPP_REG_ALT + TPP_AW'(g);
    localparam logic [TPP_AW-1:0] SPRI_ADDR = TPP_REG_SHADOW + TPP_SHADOW_STRIDE * TPP_AW'(g);
    localparam logic [TPP_AW-1:0] SALT_ADDR = SPRI_ADDR + 5'h01;

    logic [TPP_DW-1:0] next_pri, next_alt;
    logic [TPP_DW-1:0] cmpSel;
    logic [TPP_DW+1:0] per1, sumA, sumB, sawA, sawB, dead18;
    logic next_risk;

    always_comb
    begin
      next_pri = cmpPri[g];
      next_alt = cmpAlt[g];
      if (wr && (addr == PRI_ADDR || addr == SPRI_ADDR))
      begin
        next_pri = wdata;
      end
      if (wr && (addr == ALT_ADDR || addr == SALT_ADDR))
      begin
        next_alt = wdata;
      end
    end

    always_comb
    begin
      per1 = {2'b00, period} + 18'h0_0001;
      dead18 = {10'h000, deadValue};
      sumA = per1 - {2'b00, cmpAlt[g]} + {2'b00, cmpPri[g]};
      sumB = {2'b00, cmpAlt[g]} + per1 - {2'b00, cmpPri[g]};
      sawA = per1 - {2'b00, cmpAlt[g]} - 18'h0_0001;
      sawB = {2'b00, cmpPri[g]} - 18'h0_0001;
      next_risk = 1'b0;
      if (cfg.deadEn && !cfg.deadDiv2)
      begin
        case (cfg.mode)
          TPP_MODE_TRI0: next_risk = ($signed(sumB) < $signed(dead18)) || ($signed(sumA) < $signed(dead18));
          TPP_MODE_TRI1: next_risk = ($signed(sumA) < $signed(dead18)) || ($signed(sumB) < $signed(dead18));
          TPP_MODE_SAW: next_risk = ($signed(sawA) < $signed(dead18)) || ($signed(sawB) < $signed(dead18));
          default: next_risk = 1'b0;
        endcase
      end
    end

    always_ff @(posedge mclk)
    begin
      if (srst)
      begin
        cmpPri[g] <= TPP_CMP_RST;
        cmpAlt[g] <= TPP_CMP_RST;
        risk[g] <= 1'b0;
        phaseHi[g] <= 1'b0;
        phaseLo[g] <= 1'b0;
      end
      else if (ce)
      begin
        cmpPri[g] <= next_pri;
        cmpAlt[g] <= next_alt;
        risk[g] <= next_risk;
        phaseHi[g] <= driveHi[g];
        phaseLo[g] <= driveLo[g];
      end
    end

    assign cmpSel = (cfg.mode == TPP_MODE_TRI1 && half) ? cmpAlt[g] : cmpPri[g];
    assign driveHi[g] = drive[g].hi;
    assign driveLo[g] = drive[g].lo;

    tpp_phase uPhase (
      .mclk(mclk),
      .srst(srst),
      .ce(ce),
      .start(phaseStart),
      .running(phasesRun || phaseStart),
      .cmp(cmpSel),
      .cmpCount(cmpSel > cmpMin),
      .cmpEdge((cmpSel > cmpMin) && (cmpSel <= cmpLimit)),
      .loadLevel(loadLevel),
      .startLevel(startLevel),
      .expLevel(expLevel),
      .deadValue(deadValue),
      .deadEn(cfg.deadEn),
      .deadTick(deadTick),
      .drive(drive[g]),
      .lost(lostPulse[g])
    );
  end

endmodule : tpp_pwm

// *** tb/tpp_power_stage.sv ***
`timescale 1ns/10ps
module tpp_power_stage
  import tpp_pkg::*;
(
  input wire logic mclk,
  input wire logic [TPP_PH-1:0] phaseHi,
  input wire logic [TPP_PH-1:0] phaseLo,
  output logic [TPP_PH-1:0] phaseOut,
  output int shootCount
);
  // ****
  // half bridges; an undriven node drifts
  // ****
  initial shootCount = 0;
  initial phaseOut = '0;
  always @(posedge mclk)
  begin
    if (|(phaseHi & phaseLo))
      shootCount <= shootCount + 1;
    for (int i = 0; i < TPP_PH; i++)
      phaseOut[i] <= phaseHi[i] ? 1'b1 : (phaseLo[i] ? 1'b0 : ~phaseOut[i]);
  end
endmodule : tpp_power_stage

// *** tb/tpp_pwm_asserts.sv ***
`timescale 1ns/10ps
module tpp_pwm_asserts
  import tpp_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [TPP_AW-1:0] addr,
  input wire logic [TPP_DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [TPP_DW-1:0] rdata,
  input wire logic [TPP_PH-1:0] phaseHi,
  input wire logic [TPP_PH-1:0] phaseLo,
  input wire logic carrierUnderflow
);
  // ****
  // checks
  // ****
  logic seenUf;
  always_ff @(posedge mclk)
  begin
    if (srst)
      seenUf <= 1'b0;
    else if (ce && wr && addr == TPP_REG_CTRL && wdata[0])
      seenUf <= 1'b0;
    else if (carrierUnderflow)
      seenUf <= 1'b1;
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  sequence s_wr(a);
    ce && wr && addr == a;
  endsequence
  sequence s_rd(a);
    ce && rd && addr == a;
  endsequence
  AST_MIRROR_PRI: assert property (s_wr(TPP_REG_SHADOW) ##1 s_rd(TPP_REG_PRI) |=> rdata == $past(wdata, 2))
    else $error("mirror to primary differs");
  AST_MIRROR_ALT: assert property (s_wr(TPP_REG_SHADOW + 5'h01) ##1 s_rd(TPP_REG_ALT) |=> rdata == $past(wdata, 2))
    else $error("mirror to alternate differs");
  AST_MIRROR_W: assert property (s_wr(TPP_REG_SHADOW + 5'h04) ##1 s_rd(TPP_REG_PRI + 5'h02) |=> rdata == $past(wdata, 2))
    else $error("third phase mirror differs");
  AST_NO_SHOOT: assert property (!(|(phaseHi & phaseLo)))
    else $error("both drives of a phase on");
  AST_START_AFTER_UF: assert property ($rose(|phaseHi) |-> seenUf || carrierUnderflow || $past(carrierUnderflow))
    else $error("phase drive before first underflow");
  AST_UF_PULSE: assert property (carrierUnderflow && ce |=> !carrierUnderflow)
    else $error("underflow longer than one cycle");
  AST_STOP_IDLE: assert property (ce && wr && addr == TPP_REG_CTRL && !wdata[0]
    |-> ##[1:4] (phaseHi == 3'h0 && phaseLo == 3'h0))
    else $error("drives stay on after stop");
  AST_RD_IDLE: assert property (ce && !rd |=> rdata == 16'h0000)
    else $error("read data without read");
  AST_UNMAPPED: assert property (ce && rd && addr > 5'h0f |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule : tpp_pwm_asserts
bind tpp_pwm tpp_pwm_asserts u_asserts (.mclk(mclk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .phaseHi(phaseHi), .phaseLo(phaseLo), .carrierUnderflow(carrierUnderflow));

// *** tb/tpp_pwm_bench.sv ***
`timescale 1ns/10ps
module tpp_pwm_bench
  import tpp_pkg::*;
;
  // ****
  // harness
  // ****
  logic mclk, srst, ce, wr, rd, prevHi;
  logic [TPP_AW-1:0] addr;
  logic [TPP_DW-1:0] wdata, rdata, got;
  logic [TPP_PH-1:0] phaseHi, phaseLo, phaseOut;
  logic carrierUnderflow;
  int shootCount, errTotal = 0, samplesChecked = 0, fallCnt = 0, ufCnt = 0, f0;
  tpp_pwm dut (.mclk(mclk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .phaseHi(phaseHi), .phaseLo(phaseLo), .carrierUnderflow(carrierUnderflow));
  tpp_power_stage stage (.mclk(mclk), .phaseHi(phaseHi), .phaseLo(phaseLo), .phaseOut(phaseOut),
    .shootCount(shootCount));
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    prevHi <= phaseHi[0];
    if (prevHi && !phaseHi[0])
      fallCnt <= fallCnt + 1;
    if (carrierUnderflow)
      ufCnt <= ufCnt + 1;
  end
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task bus(input logic w, input logic r, input logic [TPP_AW-1:0] a, input logic [15:0] d);
    @(posedge mclk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
  endtask : bus
  task wr_reg(input logic [TPP_AW-1:0] a, input logic [15:0] d);
    bus(1'b1, 1'b0, a, d);
    bus(1'b0, 1'b0, a, d);
  endtask : wr_reg
  task rd_reg(input logic [TPP_AW-1:0] a);
    bus(1'b0, 1'b1, a, 16'h0000);
    bus(1'b0, 1'b0, a, 16'h0000);
    #1 got = rdata;
  endtask : rd_reg
  task rd_chk(input string what, input logic [TPP_AW-1:0] a, input logic [15:0] exp);
    rd_reg(a);
    check(what, got, exp);
  endtask : rd_chk
  task shadow_rd(input logic [TPP_AW-1:0] sa, input logic [TPP_AW-1:0] ra, input logic [15:0] v);
    bus(1'b1, 1'b0, sa, v);
    rd_chk("mirror", ra, v);
  endtask : shadow_rd
  task wait_uf(input int n);
    int target;
    target = ufCnt + n;
    for (int t = 0; t < 2000 && ufCnt < target; t++)
      @(posedge mclk);
    check("underflow", {15'h0000, ufCnt >= target}, 16'h0001);
  endtask : wait_uf
  function automatic logic [15:0] cfg(input logic en, input logic dv, input logic [1:0] m, input logic r);
    return {11'h000, en, dv, m, r};
  endfunction : cfg
  function automatic logic risk(input int m, input int p, input int a, input int b, input int d);
    if (m == 2)
      return (p - b) < d || a - 1 < d;
    return (p + 1 - a) + b < d || a + (p + 1 - b) < d;
  endfunction : risk
  // ****
  // scenarios
  // ****
  task t_reset;
    rd_chk("period", TPP_REG_PERIOD, 16'hffff);
    rd_chk("ctrl", TPP_REG_CTRL, 16'h0000);
    rd_chk("dead", TPP_REG_DEAD, 16'h0000);
    wr_reg(5'h1f, 16'h5a5a);
    rd_chk("unmapped", 5'h1f, 16'h0000);
  endtask : t_reset
  task t_mirror;
    shadow_rd(TPP_REG_SHADOW, TPP_REG_PRI, 16'h2461);
    shadow_rd(TPP_REG_SHADOW + 5'h01, TPP_REG_ALT, 16'h3572);
    shadow_rd(TPP_REG_SHADOW + 5'h04, TPP_REG_PRI + 5'h02, 16'h4683);
    for (int i = 0; i < 6; i++)
      bus(1'b1, 1'b0, TPP_REG_SHADOW + 5'(i), 16'h1100 + 16'(i));
    bus(1'b0, 1'b0, TPP_REG_CTRL, 16'h0000);
    for (int p = 0; p < TPP_PH; p++)
    begin
      rd_chk("primary", TPP_REG_PRI + 5'(p), 16'h1100 + 16'(2 * p));
      rd_chk("alternate", TPP_REG_ALT + 5'(p), 16'h1101 + 16'(2 * p));
    end
  endtask : t_mirror
  task t_start;
    wr_reg(TPP_REG_PERIOD, 16'h0007);
    wr_reg(TPP_REG_PRI, 16'h0002);
    wr_reg(TPP_REG_CTRL, cfg(1'b0, 1'b0, TPP_MODE_SAW, 1'b1));
    rd_chk("waiting", TPP_REG_STATUS, 16'h0000);
    f0 = fallCnt;
    wait_uf(1);
    repeat (3) @(posedge mclk);
    rd_chk("running", TPP_REG_STATUS, 16'h0001);
    check("first period fall", 16'(fallCnt - f0), 16'h0001);
    ce <= 1'b0;
    f0 = fallCnt;
    repeat (40) @(posedge mclk);
    check("frozen", 16'(fallCnt - f0), 16'h0000);
    check("low drive", {15'h0000, phaseLo[0]}, 16'h0001);
    check("stage out", {15'h0000, phaseOut[0]}, 16'h0000);
    ce <= 1'b1;
  endtask : t_start
  task t_edges;
    int cmpT [7] = '{0, 1, 2, 7, 8, 7, 6};
    int dvT [7] = '{0, 1, 1, 0, 0, 1, 1};
    int expT [7] = '{0, 0, 4, 4, 0, 0, 4};
    for (int k = 0; k < 7; k++)
    begin
      wr_reg(TPP_REG_CTRL, 16'h0000);
      wr_reg(TPP_REG_PRI, 16'(cmpT[k]));
      wr_reg(TPP_REG_CTRL, cfg(1'b0, 1'(dvT[k]), TPP_MODE_SAW, 1'b1));
      wait_uf(2);
      f0 = fallCnt;
      wait_uf(4);
      check("falls", 16'(fallCnt - f0), 16'(expT[k]));
    end
  endtask : t_edges
  task t_tri;
    int altT [3] = '{5, 8, 8};
    int modeT [3] = '{1, 1, 0};
    int expT [3] = '{2, 0, 2};
    for (int k = 0; k < 3; k++)
    begin
      wr_reg(TPP_REG_CTRL, 16'h0000);
      wr_reg(TPP_REG_PRI, 16'h0003);
      wr_reg(TPP_REG_ALT, 16'(altT[k]));
      wr_reg(TPP_REG_CTRL, cfg(1'b0, 1'b0, 2'(modeT[k]), 1'b1));
      wait_uf(2);
      f0 = fallCnt;
      wait_uf(4);
      check("tri falls", 16'(fallCnt - f0), 16'(expT[k]));
    end
  endtask : t_tri
  task t_lost;
    wr_reg(TPP_REG_CTRL, 16'h0000);
    wr_reg(TPP_REG_DEAD, 16'h0014);
    wr_reg(TPP_REG_CTRL, cfg(1'b1, 1'b0, TPP_MODE_SAW, 1'b1));
    wait_uf(4);
    wr_reg(TPP_REG_CTRL, 16'h0000);
    repeat (4) @(posedge mclk);
    rd_reg(TPP_REG_STATUS);
    check("lost", got & 16'h0002, 16'h0002);
    wr_reg(TPP_REG_STATUS, 16'h0002);
    rd_reg(TPP_REG_STATUS);
    check("lost clear", got & 16'h0002, 16'h0000);
  endtask : t_lost
  task t_risk;
    int tab [8][5] = '{'{0, 100, 50, 50, 101}, '{0, 100, 50, 50, 102}, '{1, 100, 10, 95, 20},
      '{1, 100, 95, 10, 20}, '{1, 100, 50, 50, 101}, '{2, 100, 21, 0, 20}, '{2, 100, 20, 0, 20}, '{2, 100, 50, 82, 20}};
    for (int k = 0; k < 8; k++)
    begin
      wr_reg(TPP_REG_CTRL, cfg(1'b1, 1'b0, 2'(tab[k][0]), 1'b0));
      wr_reg(TPP_REG_PERIOD, 16'(tab[k][1]));
      wr_reg(TPP_REG_PRI, 16'(tab[k][2]));
      wr_reg(TPP_REG_ALT, 16'(tab[k][3]));
      wr_reg(TPP_REG_DEAD, 16'(tab[k][4]));
      rd_reg(TPP_REG_STATUS);
      check("risk", {15'h0000, got[TPP_ST_RISK]},
        {15'h0000, risk(tab[k][0], tab[k][1], tab[k][2], tab[k][3], tab[k][4])});
    end
  endtask : t_risk
  task results;
    $display("checks %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  initial
  begin
    #100000;
    errTotal++;
    results();
  end
  initial
  begin
    srst = 1'b1;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    t_mirror();
    t_start();
    t_edges();
    t_tri();
    t_lost();
    t_risk();
    check("shoot", 16'(shootCount), 16'h0000);
    results();
  end
endmodule : tpp_pwm_bench
